// [src/ipr_arbiter.sv]
// Behaviour
// - priority_levels_0 bits 15:14 set clock loss/lock request level.
// - code 00 disables; 01, 10, 11 give levels 1, 2, 3.
// - requests set through priority_levels_0 never reach level 0.
// - priority_levels_0 bits 13:12 set low-voltage request level.
// - priority_levels_0 bits 9:8 set debug receive-full request level.
// - priority_levels_0 bits 7:6 set debug transmit-empty request level.
// - priority_levels_0 bits 5:4 set debug trace request level.
// - priority_levels_0 clears to zero on reset; all its requests disabled.
// - decode priority, base, fast match/vector, pending and control offsets.
// - four read-only pending registers; the last covers sources 63:49.
// - within one level the lowest-numbered source wins.
// - normal vector address is vector base joined with vector number.
// - level-2 match to a fast match register uses its fast address.
// - an enabled pending request signals wake-up to the clock control.
module ipr_arbiter import ipr_pkg::*; (
  input wire logic clk_i, // system clock, 125 MHz
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic bus_sel_i, // register access strobe
  input wire logic bus_wr_i, // 1 write, 0 read
  input wire logic [IPR_AW-1:0] bus_addr_i, // word offset from base
  input wire logic [IPR_DW-1:0] bus_wdata_i, // write data
  output logic [IPR_DW-1:0] bus_rdata_o, // read data, one cycle after strobe
  output logic bus_ack_o, // access done pulse
  input wire logic [IPR_NSRC-1:0] irq_i, // source requests, same clock
  output logic irq_req_o, // request presented to the core
  output logic [1:0] irq_ipic_o, // encoded level of that request
  output logic [20:0] vector_addr_o, // address the core jumps to
  output logic [5:0] vector_num_o, // vector number of the request
  output logic fast_o, // address came from a fast register pair
  output logic wake_o // restart clocks in wait or stop
);

  logic [15:0] prio_q [IPR_NPRIO];
  logic [15:0] prio_d [IPR_NPRIO];
  logic [15:0] vba_q, vba_d;
  logic [15:0] fim_q [2];
  logic [15:0] fim_d [2];
  logic [15:0] fival_q [2];
  logic [15:0] fival_d [2];
  logic [15:0] fivah_q [2];
  logic [15:0] fivah_d [2];
  logic int_dis_q, int_dis_d;
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [IPR_NSRC-1:0] irq_q, irq_d;
  logic [IPR_NSRC-1:0] pend;
  logic [1:0] code [IPR_NSRC];
  logic [IPR_NSRC-1:0] lvl_req [4];
  logic [3:0] lvl_found;
  logic [5:0] lvl_idx [4];
  logic win_any;
  logic [1:0] win_lvl;
  logic [5:0] win_idx;
  logic fast_hit;
  logic [20:0] fast_addr;
  logic req_q, req_d;
  logic [1:0] ipic_q, ipic_d;
  logic [20:0] vaddr_q, vaddr_d;
  logic [5:0] vnum_q, vnum_d;
  logic fast_q, fast_d;
  logic wake_q, wake_d;
  logic wr, rd;

  // writable mask per priority register
  function automatic logic [15:0] prio_mask(input int unsigned r);
    case (r)
      0: prio_mask = MASK_PRIO_0;
      1: prio_mask = MASK_PRIO_1;
      2: prio_mask = MASK_PRIO_2;
      3: prio_mask = MASK_PRIO_3;
      4: prio_mask = MASK_PRIO_4;
      5: prio_mask = MASK_PRIO_5;
      6: prio_mask = MASK_PRIO_6;
      default: prio_mask = 16'h0000;
    endcase
  endfunction

  // level of an enabled field; registers after the first are offset down by one
  function automatic logic [1:0] level_of(input int unsigned s, input logic [1:0] c);
    if (s < 8) begin
      level_of = c;
    end else begin
      level_of = c - 2'h1;
    end
  endfunction

  assign wr = bus_sel_i && bus_wr_i;
  assign rd = bus_sel_i && !bus_wr_i;

  // register write path; reserved bits masked so software zeros are moot
  always_comb begin
    for (int r = 0; r < IPR_NPRIO; r++) begin
      prio_d[r] = prio_q[r];
      if (wr && bus_addr_i == OFS_PRIO_0 + 5'(r)) begin
        prio_d[r] = bus_wdata_i & prio_mask(r);
      end
    end
    vba_d = vba_q;
    if (wr && bus_addr_i == OFS_VBA) begin
      vba_d = bus_wdata_i & MASK_VBA;
    end
    for (int k = 0; k < 2; k++) begin
      fim_d[k] = fim_q[k];
      fival_d[k] = fival_q[k];
      fivah_d[k] = fivah_q[k];
      if (wr && bus_addr_i == OFS_FAST_MATCH_0 + 5'(3 * k)) begin
        fim_d[k] = bus_wdata_i & MASK_FIM;
      end
      if (wr && bus_addr_i == OFS_FAST_VECTOR_LOW_0 + 5'(3 * k)) begin
        fival_d[k] = bus_wdata_i & MASK_FIVAL;
      end
      if (wr && bus_addr_i == OFS_FAST_VECTOR_HIGH_0 + 5'(3 * k)) begin
        fivah_d[k] = bus_wdata_i & MASK_FIVAH;
      end
    end
    int_dis_d = int_dis_q;
    if (wr && bus_addr_i == OFS_CTRL) begin
      int_dis_d = bus_wdata_i[CTRL_DIS_BIT]; // only writable control bit
    end
  end

  // configuration registers; everything clears so all sources start off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int r = 0; r < IPR_NPRIO; r++) begin
        prio_q[r] <= RST_REG;
      end
      vba_q <= RST_REG;
      for (int k = 0; k < 2; k++) begin
        fim_q[k] <= RST_REG;
        fival_q[k] <= RST_REG;
        fivah_q[k] <= RST_REG;
      end
      int_dis_q <= 1'b0;
    end else begin
      prio_q <= prio_d;
      vba_q <= vba_d;
      fim_q <= fim_d;
      fival_q <= fival_d;
      fivah_q <= fivah_d;
      int_dis_q <= int_dis_d;
    end
  end

  // per-source field codes; first register fields named explicitly
  always_comb begin
    for (int s = 0; s < IPR_NSRC; s++) begin
      if (s < 8 * IPR_NPRIO) begin
        code[s] = prio_q[s / 8][(7 - (s % 8)) * 2 +: 2];
      end else begin
        code[s] = CODE_OFF; // no field: never enabled
      end
    end
    code[0] = prio_q[0][CLK_LOSS_LSB +: 2];
    code[1] = prio_q[0][LOW_VOLT_LSB +: 2];
    code[2] = CODE_OFF; // reserved field slot
    code[3] = prio_q[0][DBG_RX_LSB +: 2];
    code[4] = prio_q[0][DBG_TX_LSB +: 2];
    code[5] = prio_q[0][DBG_TRACE_LSB +: 2];
    code[6] = prio_q[0][DBG_BKPT_LSB +: 2];
    code[7] = prio_q[0][DBG_STEP_LSB +: 2];
  end

  // sample sources once so arbitration sees a stable vector
  always_comb begin
    irq_d = irq_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= '0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // pending means requesting and enabled; sort into level groups
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      lvl_req[l] = '0;
    end
    for (int s = 0; s < IPR_NSRC; s++) begin
      pend[s] = irq_q[s] && (code[s] != CODE_OFF);
      if (pend[s]) begin
        lvl_req[level_of(s, code[s])][s] = 1'b1;
      end
    end
  end

  // one lowest-number encoder per level
  for (genvar g = 0; g < 4; g++) begin : g_lvl
    ipr_lowest_first #(.N(IPR_NSRC)) u_enc (
      .req_i(lvl_req[g]),
      .found_o(lvl_found[g]),
      .idx_o(lvl_idx[g])
    );
  end

  // highest level first, then its lowest-numbered source
  always_comb begin
    win_any = 1'b0;
    win_lvl = 2'h0;
    win_idx = '0;
    for (int l = 0; l < 4; l++) begin
      if (lvl_found[l]) begin
        win_any = 1'b1;
        win_lvl = 2'(l);
        win_idx = lvl_idx[l];
      end
    end
  end

  ipr_fast_match u_fast (
    .vec_i(win_idx),
    .level_i(win_lvl),
    .fast_match_0_i(fim_q[0]),
    .fast_match_1_i(fim_q[1]),
    .addr0_i({fivah_q[0][4:0], fival_q[0]}),
    .addr1_i({fivah_q[1][4:0], fival_q[1]}),
    .hit_o(fast_hit),
    .addr_o(fast_addr)
  );

  // request to the core; disable bit gates it but not the wake-up
  always_comb begin
    req_d = win_any && !int_dis_q;
    vnum_d = win_idx;
    fast_d = fast_hit && req_d;
    if (fast_hit) begin
      vaddr_d = fast_addr;
    end else begin
      vaddr_d = {vba_q[13:0], 1'b0, win_idx};
    end
    case (win_lvl)
      2'h0: ipic_d = IPIC_L0;
      2'h1: ipic_d = IPIC_L1;
      default: ipic_d = IPIC_L23;
    endcase
    if (!req_d) begin
      ipic_d = IPIC_NONE;
    end
    wake_d = |pend;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_q <= 1'b0;
      ipic_q <= IPIC_NONE;
      vaddr_q <= '0;
      vnum_q <= '0;
      fast_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      req_q <= req_d;
      ipic_q <= ipic_d;
      vaddr_q <= vaddr_d;
      vnum_q <= vnum_d;
      fast_q <= fast_d;
      wake_q <= wake_d;
    end
  end

  // read mux; unmapped offsets answer zero so software sees no garbage
  always_comb begin
    rdata_d = rdata_q;
    ack_d = bus_sel_i;
    if (rd) begin
      rdata_d = 16'h0000;
      if (bus_addr_i <= OFS_PRIO_6) begin
        rdata_d = prio_q[bus_addr_i[2:0]];
      end else if (bus_addr_i == OFS_VBA) begin
        rdata_d = vba_q;
      end else if (bus_addr_i == OFS_FAST_MATCH_0) begin
        rdata_d = fim_q[0];
      end else if (bus_addr_i == OFS_FAST_VECTOR_LOW_0) begin
        rdata_d = fival_q[0];
      end else if (bus_addr_i == OFS_FAST_VECTOR_HIGH_0) begin
        rdata_d = fivah_q[0];
      end else if (bus_addr_i == OFS_FAST_MATCH_1) begin
        rdata_d = fim_q[1];
      end else if (bus_addr_i == OFS_FAST_VECTOR_LOW_1) begin
        rdata_d = fival_q[1];
      end else if (bus_addr_i == OFS_FAST_VECTOR_HIGH_1) begin
        rdata_d = fivah_q[1];
      end else if (bus_addr_i == OFS_PEND_0) begin
        rdata_d = {pend[16:2], 1'b1};
      end else if (bus_addr_i == OFS_PEND_0 + 5'h01) begin
        rdata_d = pend[32:17];
      end else if (bus_addr_i == OFS_PEND_0 + 5'h02) begin
        rdata_d = pend[48:33];
      end else if (bus_addr_i == OFS_PEND_3) begin
        rdata_d = {1'b0, pend[63:49]};
      end else if (bus_addr_i == OFS_CTRL) begin
        rdata_d = CTRL_FIXED;
        rdata_d[CTRL_INT_BIT] = req_q;
        rdata_d[CTRL_IPIC_LSB +: 2] = ipic_q;
        rdata_d[CTRL_VAB_LSB +: 7] = {1'b0, vnum_q};
        rdata_d[CTRL_DIS_BIT] = int_dis_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign bus_rdata_o = rdata_q;
  assign bus_ack_o = ack_q;
  assign irq_req_o = req_q;
  assign irq_ipic_o = ipic_q;
  assign vector_addr_o = vaddr_q;
  assign vector_num_o = vnum_q;
  assign fast_o = fast_q;
  assign wake_o = wake_q;

endmodule

// [src/ipr_pkg.sv]
package ipr_pkg;

  // bus and data widths, source count and priority register count
  localparam int unsigned IPR_AW = 5;
  localparam int unsigned IPR_DW = 16;
  localparam int unsigned IPR_NSRC = 64;
  localparam int unsigned IPR_NPRIO = 7;

  // register offsets, in bus words from the block base
  localparam logic [4:0] OFS_PRIO_0 = 5'h00;
  localparam logic [4:0] OFS_PRIO_6 = 5'h06;
  localparam logic [4:0] OFS_VBA = 5'h07;
  localparam logic [4:0] OFS_FAST_MATCH_0 = 5'h08;
  localparam logic [4:0] OFS_FAST_VECTOR_LOW_0 = 5'h09;
  localparam logic [4:0] OFS_FAST_VECTOR_HIGH_0 = 5'h0a;
  localparam logic [4:0] OFS_FAST_MATCH_1 = 5'h0b;
  localparam logic [4:0] OFS_FAST_VECTOR_LOW_1 = 5'h0c;
  localparam logic [4:0] OFS_FAST_VECTOR_HIGH_1 = 5'h0d;
  localparam logic [4:0] OFS_PEND_0 = 5'h0e;
  localparam logic [4:0] OFS_PEND_3 = 5'h11;
  localparam logic [4:0] OFS_CTRL = 5'h16;

  // writable bit masks; reserved bits read zero and drop writes
  localparam logic [15:0] MASK_PRIO_0 = 16'hf3ff;
  localparam logic [15:0] MASK_PRIO_1 = 16'hffff;
  localparam logic [15:0] MASK_PRIO_2 = 16'hc3ff;
  localparam logic [15:0] MASK_PRIO_3 = 16'hc03f;
  localparam logic [15:0] MASK_PRIO_4 = 16'hffff;
  localparam logic [15:0] MASK_PRIO_5 = 16'hff00;
  localparam logic [15:0] MASK_PRIO_6 = 16'h0fff;
  localparam logic [15:0] MASK_VBA = 16'h3fff;
  localparam logic [15:0] MASK_FIM = 16'h003f;
  localparam logic [15:0] MASK_FIVAL = 16'hffff;
  localparam logic [15:0] MASK_FIVAH = 16'h001f;

  // field positions inside priority_levels_0 (lsb of each 2-bit field)
  localparam int unsigned CLK_LOSS_LSB = 14;
  localparam int unsigned LOW_VOLT_LSB = 12;
  localparam int unsigned DBG_RX_LSB = 8;
  localparam int unsigned DBG_TX_LSB = 6;
  localparam int unsigned DBG_TRACE_LSB = 4;
  localparam int unsigned DBG_BKPT_LSB = 2;
  localparam int unsigned DBG_STEP_LSB = 0;

  // control/status fields
  localparam int unsigned CTRL_INT_BIT = 15;
  localparam int unsigned CTRL_IPIC_LSB = 13;
  localparam int unsigned CTRL_VAB_LSB = 6;
  localparam int unsigned CTRL_DIS_BIT = 5;
  localparam logic [15:0] CTRL_FIXED = 16'h001c;

  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [1:0] CODE_OFF = 2'h0;

  // level codes presented to the core
  localparam logic [1:0] IPIC_NONE = 2'h0;
  localparam logic [1:0] IPIC_L0 = 2'h1;
  localparam logic [1:0] IPIC_L1 = 2'h2;
  localparam logic [1:0] IPIC_L23 = 2'h3;

endpackage

// [src/ipr_lowest_first.sv]
// lowest-numbered active request wins
module ipr_lowest_first import ipr_pkg::*; #(
  parameter int unsigned N = 64
) (
  input wire logic [N-1:0] req_i, // active requests of one level
  output logic found_o, // any request active
  output logic [$clog2(N)-1:0] idx_o // number of the winner
);

  // scan downward so the smallest index is the last to overwrite
  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o = ($clog2(N))'(i);
      end
    end
  end

endmodule

// [src/ipr_fast_match.sv]
// fast-interrupt lookup: only a level-2 request may take a fast address
module ipr_fast_match import ipr_pkg::*; (
  input wire logic [5:0] vec_i, // winning vector number
  input wire logic [1:0] level_i, // winning priority level
  input wire logic [15:0] fast_match_0_i, // match value 0
  input wire logic [15:0] fast_match_1_i, // match value 1
  input wire logic [20:0] addr0_i, // fast address 0
  input wire logic [20:0] addr1_i, // fast address 1
  output logic hit_o, // fast handling applies
  output logic [20:0] addr_o // fast vector address
);

  // match 0 has precedence when software programs both equal
  always_comb begin
    hit_o = 1'b0;
    addr_o = '0;
    if (level_i == 2'h2) begin
      if (fast_match_0_i[5:0] == vec_i) begin
        hit_o = 1'b1;
        addr_o = addr0_i;
      end else if (fast_match_1_i[5:0] == vec_i) begin
        hit_o = 1'b1;
        addr_o = addr1_i;
      end
    end
  end

endmodule

// [tb/ipr_arbiter_asserts.sv]
module ipr_arbiter_asserts import ipr_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic bus_sel_i, // strobe
  input wire logic bus_wr_i, // write
  input wire logic [IPR_AW-1:0] bus_addr_i, // offset
  input wire logic [IPR_DW-1:0] bus_wdata_i, // wdata
  input wire logic [IPR_DW-1:0] bus_rdata_o, // rdata
  input wire logic bus_ack_o, // done
  input wire logic [IPR_NSRC-1:0] irq_i, // sources
  input wire logic irq_req_o, // to core
  input wire logic [1:0] irq_ipic_o, // level code
  input wire logic [20:0] vector_addr_o, // vector
  input wire logic [5:0] vector_num_o, // winner
  input wire logic fast_o, // fast pair
  input wire logic wake_o // wake-up
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic rd_w;
  logic hi_w;
  // read strobe; sources above 7 may legally sit at level 0
  assign rd_w = bus_sel_i && !bus_wr_i;
  assign hi_w = |irq_i[63:8];
  ack_follows_a: assert property (bus_sel_i |=> bus_ack_o)
    else $error("no ack after strobe");
  resv_zero_a: assert property (rd_w && bus_addr_i == OFS_PRIO_0 |=> bus_rdata_o[11:10] == 2'h0)
    else $error("reserved bits read nonzero");
  pend_top_a: assert property (rd_w && bus_addr_i == OFS_PEND_3 |=> !bus_rdata_o[15])
    else $error("pending top bit set");
  ctrl_fixed_a: assert property (rd_w && bus_addr_i == OFS_CTRL |=> bus_rdata_o[4:0] == 5'h1c)
    else $error("fixed control bits wrong");
  idle_quiet_a: assert property ($past(irq_i, 2) == '0 |-> !irq_req_o && !wake_o)
    else $error("request without source");
  no_level0_a: assert property (irq_req_o && !$past(hi_w, 2) |-> irq_ipic_o != IPIC_L0)
    else $error("level 0 from low sources");
  vec_concat_a: assert property (irq_req_o && !fast_o |-> vector_addr_o[6:0] == {1'b0, vector_num_o})
    else $error("vector address low part wrong");
  fast_level_a: assert property (fast_o |-> irq_req_o && irq_ipic_o == IPIC_L23)
    else $error("fast without level 2");
endmodule

bind ipr_arbiter ipr_arbiter_asserts i_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_sel_i(bus_sel_i),
  .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
  .bus_ack_o(bus_ack_o), .irq_i(irq_i), .irq_req_o(irq_req_o), .irq_ipic_o(irq_ipic_o),
  .vector_addr_o(vector_addr_o), .vector_num_o(vector_num_o), .fast_o(fast_o), .wake_o(wake_o));

// [tb/ipr_core_model.sv]
module ipr_core_model import ipr_pkg::*; (
  input wire logic clk_i, // clock
  output logic bus_sel_o, // strobe
  output logic bus_wr_o, // write
  output logic [IPR_AW-1:0] bus_addr_o, // offset
  output logic [IPR_DW-1:0] bus_wdata_o, // wdata
  input wire logic [IPR_DW-1:0] bus_rdata_i, // rdata
  input wire logic bus_ack_i // done
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    bus_sel_o = 1'b0;
    bus_wr_o = 1'b0;
    bus_addr_o = 5'h00;
    bus_wdata_o = 16'h0000;
  end
  // strobe is one cycle only, a longer one would count as a second access
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q,
                      output logic ok);
    int n;
    @(posedge clk_i);
    bus_sel_o <= 1'b1;
    bus_wr_o <= wr;
    bus_addr_o <= a;
    bus_wdata_o <= (a == OFS_PRIO_0) ? (d & 16'hf3ff) : d;
    @(posedge clk_i);
    bus_sel_o <= 1'b0;
    bus_wdata_o <= ~d; // released data shows junk
    ok = 1'b0;
    q = 16'h0000;
    // answer taken at the rising edge where ack is seen high, before it drops
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clk_i);
      ok = bus_ack_i;
      q = bus_rdata_i;
    end
  endtask
endmodule

// [tb/interrupt_priority_register_bank_test.sv]
module interrupt_priority_register_bank_test import ipr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MASKS [14] = '{MASK_PRIO_0, MASK_PRIO_1, MASK_PRIO_2, MASK_PRIO_3, MASK_PRIO_4,
    MASK_PRIO_5, MASK_PRIO_6, MASK_VBA, MASK_FIM, MASK_FIVAL, MASK_FIVAH, MASK_FIM, MASK_FIVAL, MASK_FIVAH};
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sel, wr_s, ack, req, fast, wake, ok, en;
  logic [4:0] addr;
  logic [15:0] wd, rdat, r, d, vector_table_base;
  logic [63:0] irq = '0;
  logic [63:0] v;
  logic [1:0] ipic;
  logic [20:0] vaddr;
  logic [5:0] vnum;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 20117;
  int k, s, c;

  always #4 clk_i = ~clk_i;

  ipr_core_model i_core (.clk_i(clk_i), .bus_sel_o(sel), .bus_wr_o(wr_s), .bus_addr_o(addr),
    .bus_wdata_o(wd), .bus_rdata_i(rdat), .bus_ack_i(ack));
  ipr_arbiter i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_sel_i(sel), .bus_wr_i(wr_s), .bus_addr_i(addr),
    .bus_wdata_i(wd), .bus_rdata_o(rdat), .bus_ack_o(ack), .irq_i(irq), .irq_req_o(req), .irq_ipic_o(ipic),
    .vector_addr_o(vaddr), .vector_num_o(vnum), .fast_o(fast), .wake_o(wake));

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] dd);
    i_core.xfer(1'b1, a, dd, r, ok);
    chk(ok, 1);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    i_core.xfer(1'b0, a, 16'h0000, r, ok);
    chk({ok, r}, {1'b1, e});
  endtask
  // sources settle two edges after they change
  task automatic apply_irq(input logic [63:0] vv);
    @(posedge clk_i);
    irq <= vv;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // code 01 is level 1, 10 and 11 share the top code
  function automatic logic [1:0] exp_ipic(input logic [1:0] code);
    return (code == 2'h0) ? IPIC_NONE : (code == 2'h1) ? IPIC_L1 : IPIC_L23;
  endfunction
  function automatic logic [5:0] lowest(input logic [63:0] vv);
    lowest = 6'h00;
    for (int i = 63; i >= 0; i--) if (vv[i]) lowest = i[5:0];
  endfunction

  // hang guard, far beyond the expected run
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (k = 0; k < 24; k++) begin
      rd_chk(k[4:0], k == 14 ? 16'h0001 : k == 22 ? 16'h001c : 16'h0000);
    end
    // random writes keep only writable bits; read-only and holes stay put
    for (k = 0; k < 22; k++) begin
      d = 16'($random(seed));
      wr(k[4:0], d);
      rd_chk(k[4:0], k == 14 ? 16'h0001 : k < 14 ? d & MASKS[k] : 16'h0000);
      wr(k[4:0], 16'h0000);
    end
    // every code of the fields of sources 0 to 5, one source alone
    for (s = 0; s < 6; s++) begin
      for (c = 0; c < 4; c++) begin
        en = s != 2 && c != 0;
        wr(OFS_PRIO_0, 16'(c) << (14 - 2 * s));
        apply_irq(64'h1 << s);
        chk({req, ipic, wake}, {en, en ? exp_ipic(c[1:0]) : IPIC_NONE, en});
        if (en) chk(vnum, s);
        rd_chk(OFS_PEND_0, s > 2 && en ? 16'h0001 | (16'h1 << (s - 1)) : 16'h0001);
      end
    end
    // one level for all priority_levels_0 sources: lowest number wins, base joins the number
    wr(OFS_PRIO_0, 16'hffff);
    for (k = 0; k < 16; k++) begin
      vector_table_base = 16'($random(seed));
      wr(OFS_VBA, vector_table_base);
      v = {8'($random(seed)), 50'h0, 6'($random(seed)) & 6'h3b};
      if (v[5:0] == 6'h00) v[5] = 1'b1;
      apply_irq(v);
      chk({req, vnum, vaddr}, {1'b1, lowest(v), vector_table_base[13:0], 1'b0, lowest(v)});
    end
    // fast pair k answers a level-2 match on source 4, level 3 does not
    for (k = 0; k < 2; k++) begin
      d = 16'($random(seed));
      wr(OFS_PRIO_0, 16'h0080);
      wr(OFS_FAST_MATCH_0 + 5'(3 * k), 16'h0004);
      wr(OFS_FAST_MATCH_1 - 5'(3 * k), 16'h0005);
      wr(OFS_FAST_VECTOR_LOW_0 + 5'(3 * k), d);
      wr(OFS_FAST_VECTOR_HIGH_0 + 5'(3 * k), ~d);
      apply_irq(64'h10);
      chk({fast, vaddr}, {1'b1, ~d[4:0], d});
      wr(OFS_PRIO_0, 16'h00c0);
      apply_irq(64'h10);
      chk({fast, vaddr}, {1'b0, vector_table_base[13:0], 1'b0, 6'h04});
    end
    // disable stops the request; wake-up and pending still report
    wr(OFS_CTRL, 16'hffff);
    wr(OFS_PRIO_6, 16'hffff);
    apply_irq('1);
    chk({req, ipic, fast, wake}, 5'h01);
    i_core.xfer(1'b0, OFS_CTRL, 16'h0000, r, ok);
    chk(r[5:0], 6'h3c);
    rd_chk(OFS_PEND_3, 16'h007e);
    // level-0 codes from a later register; source 4 dropped so level 0 is top
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_PRIO_6, 16'h0555);
    apply_irq(~64'h10);
    chk({req, ipic, fast, vnum, vaddr}, {1'b1, IPIC_L0, 1'b0, 6'h32, vector_table_base[13:0], 1'b0, 6'h32});
    rd_chk(OFS_CTRL, {1'b1, IPIC_L0, 7'h32, 1'b0, 3'h7, 2'h0});
    // second reset in mid-run clears the configuration
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk(OFS_PRIO_0, 16'h0000);
    @(negedge clk_i);
    chk({req, wake}, 2'h0);
    tally_and_finish();
  end
endmodule
